// >>> hdl/pqmap_map.svh
/*
 Register map, field layout, reset values and bus constants of the priority
 queue mapping block. Assumes it is included by bare name from hdl/.
*/
`ifndef PQMAP_MAP_SVH
`define PQMAP_MAP_SVH

// Printed offsets are register indices; byte address is four times the index
`define PQMAP_TAG_MAP_IDX     8'h0E
`define PQMAP_TOS_MAP_IDX     8'h0F
`define PQMAP_TAG_MAP_ADDR    8'h38
`define PQMAP_TOS_MAP_ADDR    8'h3C
`define PQMAP_ADDR_W          8
`define PQMAP_MAP_W           16
`define PQMAP_SEL_W           2
`define PQMAP_TAG_MAP_RST     16'hFA50
// No reset value printed for the TOS map; same default as the tag map
`define PQMAP_TOS_MAP_RST     16'hFA50
`define PQMAP_UNMAPPED_RDATA  32'h0000_0000
// Low bit of each two-bit queue selector, levels 7 down to 0
`define PQMAP_QUEUE_SEL_LEVEL7_LSB 14
`define PQMAP_QUEUE_SEL_LEVEL6_LSB 12
`define PQMAP_QUEUE_SEL_LEVEL5_LSB 10
`define PQMAP_QUEUE_SEL_LEVEL4_LSB 8
`define PQMAP_QUEUE_SEL_LEVEL3_LSB 6
`define PQMAP_QUEUE_SEL_LEVEL2_LSB 4
`define PQMAP_QUEUE_SEL_LEVEL1_LSB 2
`define PQMAP_QUEUE_SEL_LEVEL0_LSB 0

`endif

// >>> hdl/pqmap_pkg.sv
/*
 Types of the priority queue mapping block.
 Assumes pqmap_map.svh provides the widths.
*/
`include "pqmap_map.svh"
package pqmap_pkg;

   typedef logic [`PQMAP_SEL_W-1:0] pqmap_queue_t;

   // Classification request from the packet classifier
   typedef struct packed {
      logic       valid;
      logic       is_tagged;
      logic       is_ip;
      logic [2:0] user_prio;
      logic [2:0] tos_prec;
   } pqmap_req_t;

   // Registered classification answer
   typedef struct packed {
      logic         valid;
      logic         tag_hit;
      logic         tos_hit;
      pqmap_queue_t tag_queue;
      pqmap_queue_t tos_queue;
   } pqmap_ans_t;

   typedef enum logic [0:0] {
      PQMAP_IDLE = 1'b0,
      PQMAP_DONE = 1'b1
   } pqmap_bus_state_t;

endpackage : pqmap_pkg

// >>> hdl/pqmap_top.sv
/*
 Priority queue mapping registers with Avalon-MM slave and a one-cycle
 classification lookup. Assumes one clock, synchronous active-low reset and
 a classifier that presents a request for one cycle per packet.
*/
`timescale 1ns/100ps
`include "pqmap_map.svh"

// Overview of operation
// - Tagged priority 7..4 selects tag-map bits 15:14, 13:12, 11:10, 9:8
// - Tagged priority 3..0 selects tag-map bits 7:6, 5:4, 3:2, 1:0
// - TOS precedence 7..4 selects TOS-map bits 15:14, 13:12, 11:10, 9:8
// - TOS precedence 3..0 selects TOS-map bits 7:6, 5:4, 3:2, 1:0
// - Each two-bit selector names its queue directly, 00 to 11
module pqmap_top
   import pqmap_pkg::*;
#(
   parameter int ADDR_W = `PQMAP_ADDR_W
) (
   input  wire logic              clock_i,
   input  wire logic              nrst_i,
   input  wire logic [ADDR_W-1:0] avs_address_i,
   input  wire logic              avs_read_i,
   input  wire logic              avs_write_i,
   input  wire logic [31:0]       avs_writedata_i,
   input  wire logic [3:0]        avs_byteenable_i,
   output logic [31:0]            avs_readdata_o,
   output logic                   avs_waitrequest_o,
   input  wire pqmap_req_t        cls_req_i,
   output pqmap_ans_t             cls_ans_o
);

   if (ADDR_W < 6) begin : g_addr_w_check
      $error("ADDR_W too small to reach the map registers");
   end

   // Selector for a three-bit level out of an eight-entry map
   function automatic pqmap_queue_t pick_queue(input logic [15:0] map,
                                               input logic [2:0]  level);
      pick_queue = map[{level, 1'b0} +: 2];
   endfunction : pick_queue

   function automatic logic [15:0] merge_be(input logic [15:0] old_v,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
      merge_be = {be[1] ? wd[15:8] : old_v[15:8], be[0] ? wd[7:0] : old_v[7:0]};
   endfunction : merge_be

   logic [15:0]      tag_map_reg, tag_map_next;
   logic [15:0]      tos_map_reg, tos_map_next;
   logic [31:0]      rdata_reg, rdata_next;
   pqmap_bus_state_t state_reg, state_next;
   pqmap_ans_t       ans_reg, ans_next;
   logic             hit_tag, hit_tos;

   assign hit_tag = (avs_address_i == ADDR_W'(`PQMAP_TAG_MAP_ADDR));
   assign hit_tos = (avs_address_i == ADDR_W'(`PQMAP_TOS_MAP_ADDR));

   // One wait cycle per access keeps read data registered
   assign avs_waitrequest_o = (avs_read_i | avs_write_i) && (state_reg == PQMAP_IDLE);
   assign avs_readdata_o    = rdata_reg;

   always_comb begin
      tag_map_next = tag_map_reg;
      tos_map_next = tos_map_reg;
      rdata_next   = rdata_reg;
      state_next   = PQMAP_IDLE;
      case (state_reg)
         PQMAP_IDLE: begin
            if (avs_read_i | avs_write_i) begin
               state_next = PQMAP_DONE;
               if (avs_read_i) begin
                  if (hit_tag) begin
                     rdata_next = {16'h0000, tag_map_reg};
                  end else if (hit_tos) begin
                     rdata_next = {16'h0000, tos_map_reg};
                  end else begin
                     rdata_next = `PQMAP_UNMAPPED_RDATA;
                  end
               end
            end
         end
         PQMAP_DONE: begin
            // Write lands at the edge where waitrequest is seen low
            if (avs_write_i && hit_tag) begin
               tag_map_next = merge_be(tag_map_reg, avs_writedata_i, avs_byteenable_i);
            end
            if (avs_write_i && hit_tos) begin
               tos_map_next = merge_be(tos_map_reg, avs_writedata_i, avs_byteenable_i);
            end
         end
         default: state_next = PQMAP_IDLE;
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         tag_map_reg <= `PQMAP_TAG_MAP_RST;
         tos_map_reg <= `PQMAP_TOS_MAP_RST;
         rdata_reg   <= 32'h0000_0000;
         state_reg   <= PQMAP_IDLE;
      end else begin
         tag_map_reg <= tag_map_next;
         tos_map_reg <= tos_map_next;
         rdata_reg   <= rdata_next;
         state_reg   <= state_next;
      end
   end

   // Lookup: selectors pass straight through as queue numbers
   always_comb begin
      ans_next           = '0;
      ans_next.valid     = cls_req_i.valid;
      ans_next.tag_hit   = cls_req_i.valid & cls_req_i.is_tagged;
      ans_next.tos_hit   = cls_req_i.valid & cls_req_i.is_ip;
      if (ans_next.tag_hit) begin
         ans_next.tag_queue = pick_queue(tag_map_reg, cls_req_i.user_prio);
      end
      if (ans_next.tos_hit) begin
         ans_next.tos_queue = pick_queue(tos_map_reg, cls_req_i.tos_prec);
      end
   end

   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         ans_reg <= '0;
      end else begin
         ans_reg <= ans_next;
      end
   end

   assign cls_ans_o = ans_reg;

   tag_high_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      cls_req_i.valid && cls_req_i.is_tagged && cls_req_i.user_prio == 3'd7
      |=> cls_ans_o.tag_queue == $past(tag_map_reg[15:14]))
      else $error("tag priority 7 queue wrong");
   tag_low_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      cls_req_i.valid && cls_req_i.is_tagged && cls_req_i.user_prio == 3'd0
      |=> cls_ans_o.tag_queue == $past(tag_map_reg[1:0]))
      else $error("tag priority 0 queue wrong");
   tos_high_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      cls_req_i.valid && cls_req_i.is_ip && cls_req_i.tos_prec == 3'd4
      |=> cls_ans_o.tos_queue == $past(tos_map_reg[9:8]))
      else $error("tos precedence 4 queue wrong");
   tos_low_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      cls_req_i.valid && cls_req_i.is_ip && cls_req_i.tos_prec == 3'd3
      |=> cls_ans_o.tos_queue == $past(tos_map_reg[7:6]))
      else $error("tos precedence 3 queue wrong");
   sel_direct_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      cls_req_i.valid && cls_req_i.is_tagged && cls_req_i.user_prio == 3'd5
      && tag_map_reg[11:10] == 2'h3 |=> cls_ans_o.tag_queue == 2'h3)
      else $error("selector not used directly");
   untag_gate_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      !cls_req_i.is_tagged |=> !cls_ans_o.tag_hit && cls_ans_o.tag_queue == 2'h0)
      else $error("tag map used on untagged frame");
   nonip_gate_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      !cls_req_i.is_ip |=> !cls_ans_o.tos_hit)
      else $error("tos map used on non-IP packet");
   wr_lands_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      avs_write_i && !avs_waitrequest_o && hit_tag && avs_byteenable_i == 4'hF
      |=> tag_map_reg == $past(avs_writedata_i[15:0]))
      else $error("tag map write lost");
   bus_wait_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      $rose(avs_read_i) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
      else $error("read answer not after one wait");

   tag_lvl6_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      cls_req_i.valid && cls_req_i.is_tagged && cls_req_i.user_prio == 3'd6
      |=> cls_ans_o.tag_queue == $past(tag_map_reg[`PQMAP_QUEUE_SEL_LEVEL6_LSB +: 2]))
      else $error("tag priority 6 queue wrong");
   tag_lvl5_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      cls_req_i.valid && cls_req_i.is_tagged && cls_req_i.user_prio == 3'd5
      |=> cls_ans_o.tag_queue == $past(tag_map_reg[`PQMAP_QUEUE_SEL_LEVEL5_LSB +: 2]))
      else $error("tag priority 5 queue wrong");
   tag_lvl4_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      cls_req_i.valid && cls_req_i.is_tagged && cls_req_i.user_prio == 3'd4
      |=> cls_ans_o.tag_queue == $past(tag_map_reg[`PQMAP_QUEUE_SEL_LEVEL4_LSB +: 2]))
      else $error("tag priority 4 queue wrong");
   tag_lvl3_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      cls_req_i.valid && cls_req_i.is_tagged && cls_req_i.user_prio == 3'd3
      |=> cls_ans_o.tag_queue == $past(tag_map_reg[`PQMAP_QUEUE_SEL_LEVEL3_LSB +: 2]))
      else $error("tag priority 3 queue wrong");
   tag_lvl2_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      cls_req_i.valid && cls_req_i.is_tagged && cls_req_i.user_prio == 3'd2
      |=> cls_ans_o.tag_queue == $past(tag_map_reg[`PQMAP_QUEUE_SEL_LEVEL2_LSB +: 2]))
      else $error("tag priority 2 queue wrong");
   tag_lvl1_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      cls_req_i.valid && cls_req_i.is_tagged && cls_req_i.user_prio == 3'd1
      |=> cls_ans_o.tag_queue == $past(tag_map_reg[`PQMAP_QUEUE_SEL_LEVEL1_LSB +: 2]))
      else $error("tag priority 1 queue wrong");
   tos_lvl7_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      cls_req_i.valid && cls_req_i.is_ip && cls_req_i.tos_prec == 3'd7
      |=> cls_ans_o.tos_queue == $past(tos_map_reg[`PQMAP_QUEUE_SEL_LEVEL7_LSB +: 2]))
      else $error("tos precedence 7 queue wrong");
   tos_lvl6_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      cls_req_i.valid && cls_req_i.is_ip && cls_req_i.tos_prec == 3'd6
      |=> cls_ans_o.tos_queue == $past(tos_map_reg[`PQMAP_QUEUE_SEL_LEVEL6_LSB +: 2]))
      else $error("tos precedence 6 queue wrong");
   tos_lvl5_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      cls_req_i.valid && cls_req_i.is_ip && cls_req_i.tos_prec == 3'd5
      |=> cls_ans_o.tos_queue == $past(tos_map_reg[`PQMAP_QUEUE_SEL_LEVEL5_LSB +: 2]))
      else $error("tos precedence 5 queue wrong");
   tos_lvl2_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      cls_req_i.valid && cls_req_i.is_ip && cls_req_i.tos_prec == 3'd2
      |=> cls_ans_o.tos_queue == $past(tos_map_reg[`PQMAP_QUEUE_SEL_LEVEL2_LSB +: 2]))
      else $error("tos precedence 2 queue wrong");
   tos_lvl1_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      cls_req_i.valid && cls_req_i.is_ip && cls_req_i.tos_prec == 3'd1
      |=> cls_ans_o.tos_queue == $past(tos_map_reg[`PQMAP_QUEUE_SEL_LEVEL1_LSB +: 2]))
      else $error("tos precedence 1 queue wrong");
   tos_lvl0_a: assert property (@(posedge clock_i) disable iff (!nrst_i)
      cls_req_i.valid && cls_req_i.is_ip && cls_req_i.tos_prec == 3'd0
      |=> cls_ans_o.tos_queue == $past(tos_map_reg[`PQMAP_QUEUE_SEL_LEVEL0_LSB +: 2]))
      else $error("tos precedence 0 queue wrong");

   tag_lookup_c: cover property (@(posedge clock_i) disable iff (!nrst_i)
      cls_req_i.valid && cls_req_i.is_tagged && cls_req_i.is_ip);
   tag_write_c: cover property (@(posedge clock_i) disable iff (!nrst_i)
      avs_write_i && !avs_waitrequest_o && hit_tag);
   tos_read_c: cover property (@(posedge clock_i) disable iff (!nrst_i)
      avs_read_i && !avs_waitrequest_o && hit_tos);
   sel_code3_c: cover property (@(posedge clock_i) disable iff (!nrst_i)
      cls_req_i.valid && cls_req_i.is_tagged && tag_map_reg[11:10] == 2'h3);

endmodule : pqmap_top

// >>> dv/pqmap_cls_model.sv
/*
 Classifier model: sends one lookup request per send pulse.
 Assumes the bench drives its inputs right after a rising edge.
*/
`timescale 1ns/100ps
module pqmap_cls_model
   import pqmap_pkg::*;
(
   input  wire logic       clock_i,
   input  wire logic       nrst_i,
   input  wire logic       send_i,
   input  wire logic       tagged_i,
   input  wire logic       ip_i,
   input  wire logic [2:0] level_i,
   output pqmap_req_t      req_o
);
   // Idle fields flip so a stale value is never mistaken for data
   always_ff @(posedge clock_i) begin
      if (!nrst_i)
         req_o <= '0;
      else if (send_i)
         req_o <= {1'b1, tagged_i, ip_i, level_i, level_i};
      else
         req_o <= {1'b0, ~req_o[7:0]};
   end
endmodule : pqmap_cls_model

// >>> dv/test_priority_queue_map.sv
/*
 Bench for the priority queue mapping block: register access and lookups.
 Assumes a one-cycle lookup and an Avalon slave with wait states.
*/
`timescale 1ns/100ps
module test_priority_queue_map;
   import pqmap_pkg::*;
   logic clock_i = 0, nrst_i = 0, rd = 0, wr = 0, snd = 0, tg = 0, ip = 0;
   logic [7:0]  addr = '0;
   logic [31:0] wd = '0, rdat, rdo;
   logic [2:0]  lvl = '0;
   logic [3:0]  be = 4'hF;
   logic [15:0] tagv, tosv;
   logic        wq;
   pqmap_req_t  req;
   pqmap_ans_t  ans;
   int errors = 0, checks_done = 0;
   always #4 clock_i = ~clock_i;
   pqmap_cls_model cls (.clock_i(clock_i), .nrst_i(nrst_i), .send_i(snd), .tagged_i(tg), .ip_i(ip),
                        .level_i(lvl), .req_o(req));
   pqmap_top dut (.clock_i(clock_i), .nrst_i(nrst_i), .avs_address_i(addr),
                  .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
                  .avs_byteenable_i(be), .avs_readdata_o(rdo),
                  .avs_waitrequest_o(wq), .cls_req_i(req), .cls_ans_o(ans));
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : report_and_stop
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Request held until waitrequest is sampled low
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clock_i);
      rd <= ~w; wr <= w; addr <= a; wd <= d;
      n = 0;
      do begin
         @(posedge clock_i);
         n++;
      end while (wq !== 1'b0 && n < 50);
      rdat = rdo;
      rd <= 1'b0; wr <= 1'b0;
      if (n >= 50) begin
         errors++;
         report_and_stop();
      end
   endtask : acc
   task automatic look(input logic t, input logic i, input logic [2:0] l);
      logic [6:0] e;
      e = {1'b1, t, i, t ? tagv[2*l+:2] : 2'h0, i ? tosv[2*l+:2] : 2'h0};
      @(posedge clock_i);
      snd <= 1'b1; tg <= t; ip <= i; lvl <= l;
      @(posedge clock_i);
      snd <= 1'b0;
      @(posedge clock_i);
      #1 chk("cls_ans", 32'(e), 32'(ans));
   endtask : look
   initial begin
      repeat (4) @(posedge clock_i);
      nrst_i <= 1'b1;
      acc(1'b0, 8'h38, '0); chk("tag_map_rst", 32'h0000FA50, rdat);
      acc(1'b0, 8'h3C, '0); chk("tos_map_rst", 32'h0000FA50, rdat);
      $display("test reset values done");
      tagv = 16'hE41B; tosv = 16'h1BE4;
      acc(1'b1, 8'h38, 32'h0000E41B);
      acc(1'b1, 8'h3C, 32'h00001BE4);
      acc(1'b0, 8'h38, '0); chk("tag_map", 32'h0000E41B, rdat);
      acc(1'b0, 8'h3C, '0); chk("tos_map", 32'h00001BE4, rdat);
      acc(1'b1, 8'h40, 32'h0000FFFF);
      acc(1'b0, 8'h40, '0); chk("unmapped", 32'h0, rdat);
      acc(1'b0, 8'h38, '0); chk("tag_kept", 32'h0000E41B, rdat);
      $display("test registers done");
      // Upper lane only, then a lane that holds no map bits
      be <= 4'h2;
      acc(1'b1, 8'h38, 32'h0000FF00);
      be <= 4'h4;
      acc(1'b1, 8'h38, 32'h00FF0000);
      be <= 4'hF;
      acc(1'b0, 8'h38, '0); chk("tag_lanes", 32'h0000FF1B, rdat);
      tagv = 16'hFF1B;
      look(1'b1, 1'b0, 3'h5);
      acc(1'b1, 8'h38, 32'h0000E41B);
      tagv = 16'hE41B;
      $display("test byte lanes done");
      for (int l = 0; l < 8; l++) begin
         look(1'b1, 1'b1, 3'(l));
         look(1'b1, 1'b0, 3'(l));
         look(1'b0, 1'b1, 3'(l));
      end
      look(1'b0, 1'b0, 3'h5);
      $display("test lookups done");
      @(posedge clock_i);
      nrst_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      chk("ans_in_rst", 32'h0, 32'(ans));
      chk("rdata_in_rst", 32'h0, rdo);
      nrst_i <= 1'b1;
      acc(1'b0, 8'h38, '0); chk("tag_map_rerst", 32'h0000FA50, rdat);
      acc(1'b0, 8'h3C, '0); chk("tos_map_rerst", 32'h0000FA50, rdat);
      $display("test mid-run reset done");
      report_and_stop();
   end
endmodule : test_priority_queue_map
